//--- hw/lcc_pkg.sv
/*
 * lcc_pkg: offsets, field positions, reset values and timing for the link
 * and channel control register pair.
 * assumes: one 250 MHz system clock; registers reached by a plain byte port.
 */
package lcc_pkg;
	// ***************************************************************
	// register offsets
	// ***************************************************************
	localparam logic [7:0] LCC_LINK_CTRL_OFS = 8'h04;	// link_and_channel_control
	localparam logic [7:0] LCC_OUT_CFG_OFS   = 8'h05;	// output_and_conversion_config

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int LCC_SER_EN_BIT  = 7;	// serial_link_enable
	localparam int LCC_CFG_EN_BIT  = 6;	// config_link_enable
	localparam int LCC_PAT_EN_BIT  = 5;	// test_pattern_enable
	localparam int LCC_SLEEP_BIT   = 4;	// sleep mode
	localparam int LCC_IFT_LSB     = 2;	// local_iface_type [3:2]
	localparam int LCC_REV_EN_BIT  = 1;	// reverse_channel_enable
	localparam int LCC_FWD_EN_BIT  = 0;	// forward_channel_enable
	localparam int LCC_METHOD_BIT  = 7;	// conversion_method
	localparam int LCC_JIT_BYP_BIT = 6;	// jitter_filter_bypass
	localparam int LCC_LVL_LSB     = 4;	// output_level [5:4]
	localparam int LCC_EMPH_LSB    = 0;	// emphasis_code [3:0]

	// ***************************************************************
	// reset values and codes
	// ***************************************************************
	localparam logic [7:0] LCC_LINK_CTRL_RST = 8'h03;	// strap bits patched after release
	localparam logic [7:0] LCC_OUT_CFG_RST   = 8'h70;	// bypass=1, level=11, emphasis off
	localparam logic [1:0] LCC_IFT_I2C       = 2'h0;
	localparam logic [1:0] LCC_IFT_UART      = 2'h1;
	localparam logic [3:0] LCC_EMPH_BAD_LO   = 4'h5;	// first unusable emphasis code
	localparam logic [3:0] LCC_EMPH_BAD_HI   = 4'h7;	// last unusable emphasis code
	localparam logic [7:0] LCC_UNMAPPED_RD   = 8'h00;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int LCC_CLK_PERIOD_PS = 4000;	// 250 MHz
	localparam int LCC_BLACKOUT_US   = 500;		// reverse channel quiet time
	localparam int LCC_BLACKOUT_CYC  = (LCC_BLACKOUT_US * 1000000 + LCC_CLK_PERIOD_PS - 1) / LCC_CLK_PERIOD_PS;
endpackage

//--- hw/lcc_blk_if.sv
/*
 * lcc_blk_if: carries the reverse-channel blackout request and state between
 * the register bank and its timer.
 * assumes: both ends on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface lcc_blk_if;
	logic start;	// one-cycle pulse: link started or stopped
	logic busy;	// reverse channel blacked out
	modport ctrl (output start, input busy);
	modport tmr  (input start, output busy);
endinterface
`default_nettype wire

//--- hw/lcc_blackout_timer.sv
/*
 * lcc_blackout_timer: holds the reverse channel unusable for a fixed count of
 * cycles after each link start or stop; a new start restarts the count.
 * assumes: start is a clean one-cycle pulse in the clk_in domain.
 */
`timescale 1ns/100ps
`default_nettype none
module lcc_blackout_timer #(
	parameter int BLACKOUT_CYC = 125000	// cycles of blackout
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// request and state
	lcc_blk_if.tmr    blk
);
	localparam int CW = $clog2(BLACKOUT_CYC + 1);
	localparam logic [CW-1:0] LOAD = CW'(BLACKOUT_CYC);

	logic [CW-1:0] cnt_reg;	// cycles of blackout left
	logic [CW-1:0] cnt_next;

	// ***************************************************************
	// countdown
	// ***************************************************************
	// restart wins over counting, so a toggle inside a blackout extends it
	assign cnt_next = blk.start ? LOAD : (cnt_reg != '0 ? cnt_reg - CW'(1) : cnt_reg);
	assign blk.busy = (cnt_reg != '0);

	// register the count
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	a_blackout_start : assert property (@(posedge clk_in) disable iff (rst_in)
		blk.start |=> blk.busy && cnt_reg == LOAD) else $error("blackout did not start");
	a_blackout_end : assert property (@(posedge clk_in) disable iff (rst_in)
		(cnt_reg == CW'(1) && !blk.start) |=> !blk.busy) else $error("blackout overran");
endmodule
`default_nettype wire

//--- hw/lcc_regs.sv
/*
 * lcc_regs: link and channel control register pair of the serializer, with
 * strap sampling after reset, local channel decode and reverse-channel
 * blackout on every link start or stop.
 * assumes: synchronous byte register port driven by the control channel;
 * strap pins are steady around reset release.
 */
// What this block does
// - bit7 enables serial link; strap sets power-up
// - bit4 selects sleep; power-up from pins
// - interface field 00 I2C, 01 UART
// - upper interface codes disable local channel
// - bit1 enables reverse channel; resets to one
// - bit0 enables forward channel; resets to one
// - method bit drops register address byte
// - level field picks output amplitude; resets 11
`timescale 1ns/100ps
`default_nettype none
module lcc_regs
	import lcc_pkg::*;
#(
	parameter int BLACKOUT_CYC = lcc_pkg::LCC_BLACKOUT_CYC	// shorten for simulation
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// register port
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	output logic            reg_rvalid_out,
	// strap and select pins
	input  wire logic [1:0] config_strap_pins_in,
	input  wire logic       control_channel_select_in,
	input  wire logic       control_pin_three_in,
	input  wire logic       two_wire_select_pin_in,
	// link controls
	output logic            serial_link_enable_out,
	output logic            config_link_enable_out,
	output logic            test_pattern_enable_out,
	output logic            sleep_mode_out,
	output logic            reverse_channel_enable_out,
	output logic            reverse_rx_allowed_out,
	output logic            forward_channel_enable_out,
	// local control channel
	output logic            local_i2c_active_out,
	output logic            local_uart_active_out,
	output logic            local_channel_off_out,
	// output and conversion
	output logic            conversion_method_out,
	output logic            jitter_filter_bypass_out,
	output logic      [1:0] output_level_out,
	output logic      [3:0] emphasis_code_out
);
	// ***************************************************************
	// state
	// ***************************************************************
	logic [7:0] link_ctrl_reg;	// link_and_channel_control
	logic [7:0] link_ctrl_next;
	logic [7:0] out_cfg_reg;	// output_and_conversion_config
	logic [7:0] out_cfg_next;
	logic       strap_done_reg;	// straps taken once after release
	logic       ser_en_d_reg;	// last link enable, for toggle detect
	logic [7:0] rdata_reg;
	logic       rvalid_reg;

	lcc_blk_if blk ();

	// one place decodes the unusable emphasis codes
	function automatic logic emph_bad(input logic [3:0] code);
		emph_bad = (code >= LCC_EMPH_BAD_LO) && (code <= LCC_EMPH_BAD_HI);
	endfunction

	// ***************************************************************
	// decode
	// ***************************************************************
	wire        wr_link  = reg_wr_in && reg_addr_in == LCC_LINK_CTRL_OFS && strap_done_reg;
	wire        wr_out   = reg_wr_in && reg_addr_in == LCC_OUT_CFG_OFS;
	wire [3:0]  new_emph = reg_wdata_in[LCC_EMPH_LSB +: 4];
	// strap decode: strap bit 0 brings the link up; sleep only in the
	// pin-selected mode with the link held down
	wire        strap_ser   = config_strap_pins_in[0];
	wire        strap_sleep = control_channel_select_in & control_pin_three_in
				& ~config_strap_pins_in[0];
	wire [1:0]  ift      = link_ctrl_reg[LCC_IFT_LSB +: 2];
	wire        base_sel = ~two_wire_select_pin_in & control_channel_select_in;

	// first cycle after release loads straps; writes to link_and_channel_control in that cycle are dropped
	always_comb
	begin
		link_ctrl_next = link_ctrl_reg;
		if (!strap_done_reg)
		begin
			link_ctrl_next[LCC_SER_EN_BIT] = strap_ser;
			link_ctrl_next[LCC_SLEEP_BIT]  = strap_sleep;
		end
		else if (wr_link)
			link_ctrl_next = reg_wdata_in;
	end

	// a refused emphasis code keeps the old one; other fields still land
	always_comb
	begin
		out_cfg_next = out_cfg_reg;
		if (wr_out)
		begin
			out_cfg_next = reg_wdata_in;
			if (emph_bad(new_emph))
				out_cfg_next[LCC_EMPH_LSB +: 4] = out_cfg_reg[LCC_EMPH_LSB +: 4];
		end
	end

	// any change of the link enable, strap load included, is a start/stop
	assign blk.start = strap_done_reg && (link_ctrl_reg[LCC_SER_EN_BIT] != ser_en_d_reg);

	// ***************************************************************
	// registers
	// ***************************************************************
	// control bits; reset gives the documented constants
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			link_ctrl_reg  <= LCC_LINK_CTRL_RST;
			out_cfg_reg    <= LCC_OUT_CFG_RST;
			strap_done_reg <= 1'b0;
			ser_en_d_reg   <= 1'b0;
		end
		else
		begin
			link_ctrl_reg  <= link_ctrl_next;
			out_cfg_reg    <= out_cfg_next;
			strap_done_reg <= 1'b1;
			ser_en_d_reg   <= strap_done_reg ? link_ctrl_reg[LCC_SER_EN_BIT] : 1'b0;
		end
	end

	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rvalid_reg <= reg_rd_in;
			rdata_reg  <= (reg_addr_in == LCC_LINK_CTRL_OFS) ? link_ctrl_reg :
				      (reg_addr_in == LCC_OUT_CFG_OFS) ? out_cfg_reg : LCC_UNMAPPED_RD;
		end
	end

	// ***************************************************************
	// blackout timer
	// ***************************************************************
	lcc_blackout_timer #(
		.BLACKOUT_CYC (BLACKOUT_CYC)
	) u_timer (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.blk    (blk)
	);

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign reg_rdata_out              = rdata_reg;
	assign reg_rvalid_out             = rvalid_reg;
	assign serial_link_enable_out     = link_ctrl_reg[LCC_SER_EN_BIT];
	assign config_link_enable_out     = link_ctrl_reg[LCC_CFG_EN_BIT];
	assign test_pattern_enable_out    = link_ctrl_reg[LCC_PAT_EN_BIT];
	assign sleep_mode_out             = link_ctrl_reg[LCC_SLEEP_BIT];
	assign reverse_channel_enable_out = link_ctrl_reg[LCC_REV_EN_BIT];
	// reception needs the enable and no blackout in progress
	assign reverse_rx_allowed_out     = link_ctrl_reg[LCC_REV_EN_BIT] & ~blk.busy;
	assign forward_channel_enable_out = link_ctrl_reg[LCC_FWD_EN_BIT];
	assign local_i2c_active_out       = base_sel && ift == LCC_IFT_I2C;
	assign local_uart_active_out      = base_sel && ift == LCC_IFT_UART;
	assign local_channel_off_out      = ift[1];
	assign conversion_method_out      = out_cfg_reg[LCC_METHOD_BIT];
	assign jitter_filter_bypass_out   = out_cfg_reg[LCC_JIT_BYP_BIT];
	assign output_level_out           = out_cfg_reg[LCC_LVL_LSB +: 2];
	assign emphasis_code_out          = out_cfg_reg[LCC_EMPH_LSB +: 4];

	// ***************************************************************
	// checks
	// ***************************************************************
	sequence s_link_write;
		reg_wr_in && reg_addr_in == LCC_LINK_CTRL_OFS && strap_done_reg;
	endsequence
	sequence s_cfg_write;
		reg_wr_in && reg_addr_in == LCC_OUT_CFG_OFS;
	endsequence

	a_link_enable : assert property (@(posedge clk_in) disable iff (rst_in)
		s_link_write |=> serial_link_enable_out == $past(reg_wdata_in[7])) else $error("link enable not written");
	a_link_toggle : assert property (@(posedge clk_in) disable iff (rst_in)
		$changed(serial_link_enable_out) && $past(strap_done_reg) |=> !reverse_rx_allowed_out [*8])
		else $error("reverse channel open during blackout");
	a_sleep_write : assert property (@(posedge clk_in) disable iff (rst_in)
		s_link_write |=> sleep_mode_out == $past(reg_wdata_in[4])) else $error("sleep bit not written");
	a_iface_sel : assert property (@(posedge clk_in) disable iff (rst_in)
		local_uart_active_out |-> !two_wire_select_pin_in && control_channel_select_in && !local_i2c_active_out)
		else $error("uart active outside base mode");
	a_iface_off : assert property (@(posedge clk_in) disable iff (rst_in)
		local_channel_off_out |-> !local_i2c_active_out && !local_uart_active_out) else $error("channel not off");
	a_rev_gate : assert property (@(posedge clk_in) disable iff (rst_in)
		reverse_rx_allowed_out |-> reverse_channel_enable_out) else $error("reverse rx without enable");
	a_fwd_write : assert property (@(posedge clk_in) disable iff (rst_in)
		s_link_write |=> forward_channel_enable_out == $past(reg_wdata_in[0])) else $error("forward bit wrong");
	a_method_write : assert property (@(posedge clk_in) disable iff (rst_in)
		s_cfg_write |=> conversion_method_out == $past(reg_wdata_in[7])) else $error("method bit wrong");
	a_level_write : assert property (@(posedge clk_in) disable iff (rst_in)
		s_cfg_write |=> output_level_out == $past(reg_wdata_in[5:4])) else $error("level field wrong");
	a_pattern_write : assert property (@(posedge clk_in) disable iff (rst_in)
		s_link_write |=> test_pattern_enable_out == $past(reg_wdata_in[5])) else $error("pattern bit wrong");
	a_emph_refuse : assert property (@(posedge clk_in) disable iff (rst_in)
		s_cfg_write ##0 emph_bad(reg_wdata_in[3:0]) |=> $stable(emphasis_code_out)) else $error("bad emphasis taken");
endmodule
`default_nettype wire

//--- test/lcc_host_model.sv
/*
 * lcc_host_model: control-channel master for the register port; one-cycle
 * strobes launched on the falling edge, data lines inverted when idle.
 * assumes: reads answer exactly one cycle after the strobe edge.
 */
`timescale 1ns/100ps
`default_nettype none
module lcc_host_model (
	// clock
	input  wire logic       clk_in,
	// register port
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in
);
	// idle port at time zero
	initial
	begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// one write; idle lines show the inverse so stale data is never reused
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask

	// one read; the answer stands for a single cycle, so it is taken at once
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		ok = rvalid_in;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

//--- test/link_control_config_regs_test.sv
/*
 * link_control_config_regs_test: self-checking bench for lcc_regs.
 * assumes: blackout shortened to 20 cycles; straps give serial link on at the
 * first reset and sleep with the link down at a second, mid-run reset.
 */
`timescale 1ns/100ps
`default_nettype none
module link_control_config_regs_test;
	import lcc_pkg::*;
	localparam int BLK = 20;	// short blackout for simulation
	logic       clk_in, rst_in, wr, rd, rvalid, ccs, pin3, tws, ok;
	logic [7:0] addr, wdata, rdata, d;
	logic [1:0] straps, lvl;
	logic [3:0] emph;
	logic       ser, cfg, pat, slp, rev, rev_ok, fwd, li2c, luart, loff, meth, byp;
	int         num_errors, compares, lows;

	// ************************************************
	// clock, partner and design
	// ************************************************
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	lcc_host_model u_host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
		.rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid));

	lcc_regs #(.BLACKOUT_CYC(BLK)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .config_strap_pins_in(straps), .control_channel_select_in(ccs),
		.control_pin_three_in(pin3), .two_wire_select_pin_in(tws), .serial_link_enable_out(ser),
		.config_link_enable_out(cfg), .test_pattern_enable_out(pat), .sleep_mode_out(slp),
		.reverse_channel_enable_out(rev), .reverse_rx_allowed_out(rev_ok),
		.forward_channel_enable_out(fwd), .local_i2c_active_out(li2c),
		.local_uart_active_out(luart), .local_channel_off_out(loff),
		.conversion_method_out(meth), .jitter_filter_bypass_out(byp),
		.output_level_out(lvl), .emphasis_code_out(emph));

	// ************************************************
	// checking and closing
	// ************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// read with the strobe answer judged too
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_host.read_reg(a, d, ok);
		check({15'h0000, ok}, 16'h0001);
		check({8'h00, d}, {8'h00, exp});
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	// reset values, strap-loaded bits and an unmapped read
	task automatic t_reset();
		rd_chk(LCC_LINK_CTRL_OFS, 8'h83);
		rd_chk(LCC_OUT_CFG_OFS, 8'h70);
		rd_chk(8'h20, LCC_UNMAPPED_RD);
		repeat (BLK + 10) @(negedge clk_in);
		$display("t_reset done");
	endtask

	// each stop and start blinds the reverse channel for the full count
	task automatic t_blackout();
		logic [7:0] v [2] = '{8'h03, 8'h83};
		for (int i = 0; i < 2; i++)
		begin
			u_host.write_reg(LCC_LINK_CTRL_OFS, v[i]);
			check({15'h0, ser}, {15'h0, v[i][7]});
			lows = 0;
			repeat (BLK + 20) @(negedge clk_in) lows += (rev_ok === 1'b0);
			check(16'(lows), 16'(BLK));
		end
		$display("t_blackout done");
	endtask

	// config link, pattern, sleep, channel enables
	task automatic t_ctrl_bits();
		u_host.write_reg(LCC_LINK_CTRL_OFS, 8'h71);
		check({10'h0, ser, cfg, pat, slp, rev, fwd}, 16'h001D);
		check({15'h0, rev_ok}, 16'h0000);
		$display("t_ctrl_bits done");
	endtask

	// every local interface code, in and out of base mode
	task automatic t_iface();
		for (int i = 0; i < 4; i++)
		begin
			u_host.write_reg(LCC_LINK_CTRL_OFS, {4'h0, 2'(i), 2'h3});
			check({13'h0, li2c, luart, loff}, (i == 0) ? 16'h4 : (i == 1) ? 16'h2 : 16'h1);
			tws = 1'b1;
			@(negedge clk_in);
			check({14'h0, li2c, luart}, 16'h0000);
			tws = 1'b0;
		end
		$display("t_iface done");
	endtask

	// method, bypass, every level, and a refused emphasis code
	task automatic t_outcfg();
		for (int i = 0; i < 4; i++)
		begin
			u_host.write_reg(LCC_OUT_CFG_OFS, {i[0], ~i[0], 2'(i), 4'h4});
			check({8'h0, meth, byp, lvl, emph}, {8'h0, i[0], ~i[0], 2'(i), 4'h4});
		end
		u_host.write_reg(LCC_OUT_CFG_OFS, 8'h96);
		rd_chk(LCC_OUT_CFG_OFS, 8'h94);
		$display("t_outcfg done");
	endtask

	// mid-run reset with the link strap low: sleep comes up, link stays down,
	// so no blackout may follow and the reverse channel stays open
	task automatic t_strap_sleep();
		rst_in = 1'b1;
		straps = 2'b00;
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		rd_chk(LCC_LINK_CTRL_OFS, 8'h13);
		check({13'h0000, ser, slp, rev_ok}, 16'h0003);
		rd_chk(LCC_OUT_CFG_OFS, LCC_OUT_CFG_RST);
		$display("t_strap_sleep done");
	endtask

	// main sequence
	initial
	begin
		num_errors = 0;
		compares = 0;
		rst_in = 1'b1;
		straps = 2'b01;
		ccs = 1'b1;
		pin3 = 1'b1;
		tws = 1'b0;
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		t_reset();
		t_blackout();
		t_ctrl_bits();
		t_iface();
		t_outcfg();
		t_strap_sleep();
		stop_test();
	end
endmodule
`default_nettype wire
